// ### hw/elak_defs.svh
// constants for the lane aligner and keyed refresh registers
`ifndef ELAK_DEFS_SVH
`define ELAK_DEFS_SVH
`define ELAK_OFF_RFCNT 12'h000
`define ELAK_OFF_REFRESH_TIMER_CTRL_STATUS 12'h004
`define ELAK_OFF_REFRESH_TIMER_COUNTER 12'h008
`define ELAK_OFF_REFRESH_TIME_CONSTANT 12'h00c
`define ELAK_OFF_XCTL 12'h010
`define ELAK_OFF_XSTAT 12'h014
`define ELAK_KEY8 8'ha5
`define ELAK_KEY6 6'h29
`define ELAK_RST16 16'h0000
`define ELAK_RESP_OKAY 2'b00
`define ELAK_RESP_SLVERR 2'b10
`endif

// ### hw/elak_pkg.sv
// types for the lane aligner
package elak_pkg;
  typedef enum logic [1:0] {ELAK_SZ_BYTE, ELAK_SZ_WORD, ELAK_SZ_LONG} elak_size_type;
  typedef enum logic [1:0] {ELAK_DW_8, ELAK_DW_16, ELAK_DW_32} elak_width_type;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic write;
    elak_size_type size;
  } elak_req_type;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strobe;
    logic write;
  } elak_ext_type;
endpackage

// ### hw/elak_top.sv
// external bus lane aligner with keyed refresh-control registers
`timescale 1ns/1ps
`include "elak_defs.svh"
module elak_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // strap
  input wire logic endian_select_pin_i,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // internal access request
  input wire elak_pkg::elak_req_type req_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  output logic [31:0] rsp_rdata_o,
  output logic rsp_valid_o,
  // external bus cycle
  output elak_pkg::elak_ext_type ext_o,
  output logic ext_valid_o,
  input wire logic ext_ready_i,
  input wire logic [31:0] ext_rdata_i,
  // per-lane write strobes, active low
  output logic lane3_write_strobe_n_o,
  output logic lane2_write_strobe_n_o,
  output logic lane1_write_strobe_n_o,
  output logic lane0_write_strobe_n_o
);
  import elak_pkg::*;

  typedef enum logic [1:0] {ELAK_IDLE, ELAK_CYCLE, ELAK_DONE} elak_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // endian strap: three-stage sampler, latched once after reset release
  logic [2:0] strap_sync_q;
  logic [1:0] fill_q; // edges since release; the reset zeros in the sampler are no strap level
  logic strap_taken_q;
  logic little_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      strap_sync_q <= 3'h0;
      fill_q <= 2'd0;
      strap_taken_q <= 1'b0;
      little_q <= 1'b0;
    end else begin
      strap_sync_q <= {strap_sync_q[1:0], endian_select_pin_i};
      if (fill_q != 2'd3) fill_q <= fill_q + 2'd1;
      // wait for the pipeline to fill and two stages to agree
      if (!strap_taken_q && fill_q == 2'd3 && strap_sync_q[2] == strap_sync_q[1]) begin
        strap_taken_q <= 1'b1;
        little_q <= strap_sync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [9:0] rfcnt_q;
  logic [7:0] refresh_timer_ctrl_status_q;
  logic [7:0] refresh_timer_counter_q;
  logic [7:0] refresh_time_constant_q;
  logic [1:0] dev_width_q; // device width select, steers the aligner

  // axi write path: address and data captured in either order
  logic aw_have_q;
  logic w_have_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  wire aw_take = s_axi_awvalid_i && !aw_have_q && !bvalid_q;
  wire w_take = s_axi_wvalid_i && !w_have_q && !bvalid_q;
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_awready_o = !aw_have_q && !bvalid_q;
  assign s_axi_wready_o = !w_have_q && !bvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;

  // halfword select: the refresh register word sits in lanes 15:0 or 31:16
  wire hi_half = (w_strb_q == 4'hc);
  wire word_ok = (w_strb_q == 4'h3) || (w_strb_q == 4'hc) || (w_strb_q == 4'hf);
  wire [15:0] wr_half = hi_half ? w_data_q[31:16] : w_data_q[15:0];
  wire key8_ok = word_ok && (wr_half[15:8] == `ELAK_KEY8);
  wire key6_ok = word_ok && (wr_half[15:10] == `ELAK_KEY6);
  wire sel_rfcnt = (aw_addr_q == `ELAK_OFF_RFCNT);
  wire sel_refresh_timer_ctrl_status = (aw_addr_q == `ELAK_OFF_REFRESH_TIMER_CTRL_STATUS);
  wire sel_refresh_timer_counter = (aw_addr_q == `ELAK_OFF_REFRESH_TIMER_COUNTER);
  wire sel_refresh_time_constant = (aw_addr_q == `ELAK_OFF_REFRESH_TIME_CONSTANT);
  wire sel_xctl = (aw_addr_q == `ELAK_OFF_XCTL);
  wire sel_xstat = (aw_addr_q == `ELAK_OFF_XSTAT);
  wire wr_mapped = sel_rfcnt || sel_refresh_timer_ctrl_status || sel_refresh_timer_counter || sel_refresh_time_constant || sel_xctl || sel_xstat;

  // write handshake and keyed stores; a bad key is dropped silently
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `ELAK_RESP_OKAY;
      rfcnt_q <= 10'h000;
      refresh_timer_ctrl_status_q <= 8'h00;
      refresh_timer_counter_q <= 8'h00;
      refresh_time_constant_q <= 8'h00;
      dev_width_q <= 2'h2;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr_i[11:2], 2'b00};
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `ELAK_RESP_OKAY : `ELAK_RESP_SLVERR;
        if (sel_rfcnt && key6_ok) rfcnt_q <= wr_half[9:0];
        if (sel_refresh_timer_ctrl_status && key8_ok) refresh_timer_ctrl_status_q <= wr_half[7:0];
        if (sel_refresh_timer_counter && key8_ok) refresh_timer_counter_q <= wr_half[7:0];
        if (sel_refresh_time_constant && key8_ok) refresh_time_constant_q <= wr_half[7:0];
        if (sel_xctl && w_strb_q[0] && w_data_q[1:0] != 2'h3) dev_width_q <= w_data_q[1:0];
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read path: one answer registered the cycle after address accept
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [1:0] state_q;
  wire [11:0] ra = {s_axi_araddr_i[11:2], 2'b00};
  wire [15:0] rd_rfcnt = {6'h00, rfcnt_q};
  wire [15:0] rd_refresh_timer_ctrl_status = {8'h00, refresh_timer_ctrl_status_q};
  wire [15:0] rd_refresh_timer_counter = {8'h00, refresh_timer_counter_q};
  wire [15:0] rd_refresh_time_constant = {8'h00, refresh_time_constant_q};
  wire [31:0] rd_word = (ra == `ELAK_OFF_RFCNT) ? {16'h0000, rd_rfcnt} :
                        (ra == `ELAK_OFF_REFRESH_TIMER_CTRL_STATUS) ? {16'h0000, rd_refresh_timer_ctrl_status} :
                        (ra == `ELAK_OFF_REFRESH_TIMER_COUNTER) ? {16'h0000, rd_refresh_timer_counter} :
                        (ra == `ELAK_OFF_REFRESH_TIME_CONSTANT) ? {16'h0000, rd_refresh_time_constant} :
                        (ra == `ELAK_OFF_XCTL) ? {30'h0, dev_width_q} :
                        (ra == `ELAK_OFF_XSTAT) ? {28'h0, state_q, strap_taken_q, little_q} : 32'h0000_0000;
  wire rd_mapped = (ra <= `ELAK_OFF_XSTAT);
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  // read answer holds until rready
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ELAK_RESP_OKAY;
    end else if (!rvalid_q && s_axi_arvalid_i) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_mapped ? `ELAK_RESP_OKAY : `ELAK_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // aligner: splits one internal access into device-width beats
  elak_state_type st_q;
  elak_req_type cur_q;
  logic [1:0] beat_q;
  logic [31:0] acc_q;
  logic [31:0] rsp_q;
  assign state_q = st_q;

  // beats needed: bytes of access over bytes of device, at least one
  wire [2:0] acc_bytes = (cur_q.size == ELAK_SZ_LONG) ? 3'd4 : (cur_q.size == ELAK_SZ_WORD) ? 3'd2 : 3'd1;
  wire [2:0] dev_bytes = (dev_width_q == ELAK_DW_8) ? 3'd1 : (dev_width_q == ELAK_DW_16) ? 3'd2 : 3'd4;
  wire [1:0] last_beat = (acc_bytes > dev_bytes) ? 2'((acc_bytes / dev_bytes) - 3'd1) : 2'd0;
  // beat address ascends by the device width
  wire [31:0] beat_addr = cur_q.addr + 32'(beat_q) * 32'(dev_bytes);
  wire [1:0] bo = beat_addr[1:0];
  // bytes of the item, big-endian order: index 0 is the lowest address
  wire [31:0] item_be = (cur_q.size == ELAK_SZ_LONG) ? cur_q.data :
                        (cur_q.size == ELAK_SZ_WORD) ? {cur_q.data[15:0], 16'h0000} :
                        {cur_q.data[7:0], 24'h000000};
  // little-endian flips the byte order of the item
  wire [31:0] item_le = (cur_q.size == ELAK_SZ_LONG) ?
                        {cur_q.data[7:0], cur_q.data[15:8], cur_q.data[23:16], cur_q.data[31:24]} :
                        (cur_q.size == ELAK_SZ_WORD) ? {cur_q.data[7:0], cur_q.data[15:8], 16'h0000} :
                        {cur_q.data[7:0], 24'h000000};
  wire [31:0] item_ms = little_q ? item_le : item_be;
  // relative byte index of this beat inside the item
  wire [1:0] rel = 2'(beat_q * 2'(dev_bytes));
  wire [31:0] mem_shift = item_ms << {rel, 3'b000};
  // place memory-ordered bytes on lanes: lowest address on the high lane of the port
  logic [31:0] lane_data;
  logic [3:0] lane_en;
  always_comb begin
    lane_data = 32'h0000_0000;
    lane_en = 4'h0;
    case (dev_width_q)
      ELAK_DW_8: begin
        lane_data = {24'h000000, mem_shift[31:24]};
        lane_en = 4'h1;
      end
      ELAK_DW_16: begin
        if (acc_bytes == 3'd1) begin
          lane_data = bo[0] ? {24'h000000, mem_shift[31:24]} : {16'h0000, mem_shift[31:24], 8'h00};
          lane_en = bo[0] ? 4'h1 : 4'h2;
        end else begin
          lane_data = {16'h0000, mem_shift[31:16]};
          lane_en = 4'h3;
        end
      end
      default: begin
        lane_data = mem_shift >> {bo, 3'b000};
        lane_en = (acc_bytes == 3'd4) ? 4'hf : (acc_bytes == 3'd2) ? (bo[1] ? 4'h3 : 4'hc) : (4'h8 >> bo);
      end
    endcase
    // little-endian lanes mirror the big-endian byte placement on 16- and 32-bit devices; an 8-bit device keeps lane 0
    if (little_q && dev_width_q != ELAK_DW_8) begin
      lane_data = {lane_data[7:0], lane_data[15:8], lane_data[23:16], lane_data[31:24]};
      lane_en = {lane_en[0], lane_en[1], lane_en[2], lane_en[3]};
      if (dev_width_q == ELAK_DW_16) begin
        lane_data = {16'h0000, lane_data[31:16]};
        lane_en = {2'b00, lane_en[3:2]};
      end
    end
  end
  // gather read lanes back into memory order, then into the result
  wire [31:0] rd_lanes = little_q && dev_width_q != ELAK_DW_8 ?
                         {ext_rdata_i[7:0], ext_rdata_i[15:8], ext_rdata_i[23:16], ext_rdata_i[31:24]} : ext_rdata_i;
  wire [31:0] rd_lanes_w = (little_q && dev_width_q == ELAK_DW_16) ? (rd_lanes >> 16) : rd_lanes;
  wire [31:0] rd_mem = (dev_width_q == ELAK_DW_8) ? {ext_rdata_i[7:0], 24'h000000} :
                       (dev_width_q == ELAK_DW_16) ? ((acc_bytes == 3'd1 && bo[0]) ? {rd_lanes_w[7:0], 24'h0} :
                       {rd_lanes_w[15:0], 16'h0000}) : (rd_lanes << {bo, 3'b000});
  wire [31:0] acc_next = acc_q | (rd_mem >> {rel, 3'b000});
  wire [31:0] res_be = (cur_q.size == ELAK_SZ_LONG) ? acc_next :
                       (cur_q.size == ELAK_SZ_WORD) ? {16'h0000, acc_next[31:16]} : {24'h000000, acc_next[31:24]};
  wire [31:0] res = !little_q ? res_be : (cur_q.size == ELAK_SZ_LONG) ?
                    {acc_next[7:0], acc_next[15:8], acc_next[23:16], acc_next[31:24]} :
                    (cur_q.size == ELAK_SZ_WORD) ? {16'h0000, acc_next[23:16], acc_next[31:24]} : res_be;

  assign req_ready_o = (st_q == ELAK_IDLE) && strap_taken_q; // no access before the endian mode is known
  assign rsp_valid_o = (st_q == ELAK_DONE);
  assign rsp_rdata_o = rsp_q;
  assign ext_valid_o = (st_q == ELAK_CYCLE);
  assign ext_o.addr = beat_addr;
  assign ext_o.data = lane_data;
  assign ext_o.strobe = lane_en;
  assign ext_o.write = cur_q.write;
  // strobes asserted low only during write beats
  wire [3:0] we_act = (st_q == ELAK_CYCLE && cur_q.write) ? lane_en : 4'h0;
  assign lane3_write_strobe_n_o = !we_act[3];
  assign lane2_write_strobe_n_o = !we_act[2];
  assign lane1_write_strobe_n_o = !we_act[1];
  assign lane0_write_strobe_n_o = !we_act[0];

  // sequencer: one beat per external handshake, then one result pulse
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_q <= ELAK_IDLE;
      cur_q <= '0;
      beat_q <= 2'd0;
      acc_q <= 32'h0000_0000;
      rsp_q <= 32'h0000_0000;
    end else begin
      case (st_q)
        ELAK_IDLE: begin
          if (req_valid_i && strap_taken_q) begin
            cur_q <= req_i;
            beat_q <= 2'd0;
            acc_q <= 32'h0000_0000;
            st_q <= ELAK_CYCLE;
          end
        end
        ELAK_CYCLE: begin
          if (ext_ready_i) begin
            acc_q <= acc_next;
            if (beat_q == last_beat) begin
              rsp_q <= cur_q.write ? 32'h0000_0000 : res;
              st_q <= ELAK_DONE;
            end else begin
              beat_q <= beat_q + 2'd1;
            end
          end
        end
        default: begin
          st_q <= ELAK_IDLE;
        end
      endcase
    end
  end
endmodule // elak_top

// ### bench/elak_properties.sv
// concurrent checks on the lane aligner ports
`timescale 1ns/1ps
module elak_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register bus
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  // access side and external bus
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire elak_pkg::elak_ext_type ext_o,
  input wire logic ext_valid_o,
  input wire logic ext_ready_i,
  input wire logic lane3_write_strobe_n_o,
  input wire logic lane2_write_strobe_n_o,
  input wire logic lane1_write_strobe_n_o,
  input wire logic lane0_write_strobe_n_o
);
  import elak_pkg::*;
  // strobe pins gathered as one active-low lane vector
  wire logic [3:0] pins_n = {lane3_write_strobe_n_o, lane2_write_strobe_n_o, lane1_write_strobe_n_o,
    lane0_write_strobe_n_o};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////
  // a beat still waiting for the device
  sequence s_stall;
    ext_valid_o && !ext_ready_i;
  endsequence
  // a beat closed by the device
  sequence s_beat_end;
    ext_valid_o && ext_ready_i;
  endsequence
  ////////////////////////////////////////
  AST_BEAT_HOLD: assert property (s_stall |=> ext_valid_o && $stable(ext_o))
    else $error("beat changed before the device answered");
  AST_RSP_AFTER_BEAT: assert property (rsp_valid_o |-> $past(ext_valid_o && ext_ready_i))
    else $error("response without a closing beat");
  AST_RSP_PULSE: assert property (s_beat_end ##1 rsp_valid_o |=> !rsp_valid_o)
    else $error("response pulse longer than one cycle");
  AST_PINS_WRITE: assert property (ext_valid_o && ext_o.write |-> pins_n == ~ext_o.strobe)
    else $error("write strobe pins differ from lanes used");
  AST_PINS_IDLE: assert property (!(ext_valid_o && ext_o.write) |-> pins_n == 4'hf)
    else $error("write strobe pin low outside a write beat");
  AST_REQ_BUSY: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
    else $error("access taken while still busy");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  AST_R_NEXT: assert property (s_axi_arvalid_i && s_axi_arready_o && !s_axi_rvalid_o |=> s_axi_rvalid_o)
    else $error("read data late");
endmodule // elak_properties
bind elak_top elak_properties i_elak_properties (.clk_i, .resetn_i, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
  .req_valid_i, .req_ready_o, .rsp_valid_o, .ext_o, .ext_valid_o, .ext_ready_i, .lane3_write_strobe_n_o,
  .lane2_write_strobe_n_o, .lane1_write_strobe_n_o, .lane0_write_strobe_n_o);

// ### bench/elak_ext_mem.sv
// behavioural external device answering bus beats
`timescale 1ns/1ps
module elak_ext_mem (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // beat from the aligner
  input wire elak_pkg::elak_ext_type ext_i,
  input wire logic ext_valid_i,
  input wire logic [3:0] wait_i,
  // answer
  output logic ext_ready_o,
  output logic [31:0] ext_rdata_o
);
  import elak_pkg::*;
  logic [3:0] cnt_q;
  logic [31:0] last_q;
  // each lane carries the beat address and its own lane number, so a wrong lane choice shows;
  // released bus shows the inverse so stale data never matches
  assign ext_rdata_o = ext_ready_o ? {ext_i.addr[5:0], 2'd3, ext_i.addr[5:0], 2'd2, ext_i.addr[5:0], 2'd1,
    ext_i.addr[5:0], 2'd0} : ~last_q;
  // wait states, then one ready cycle per beat
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ext_ready_o <= 1'b0;
      cnt_q <= 4'h0;
      last_q <= 32'h0;
    end else if (ext_ready_o) begin
      ext_ready_o <= 1'b0;
      cnt_q <= 4'h0;
      last_q <= ext_rdata_o;
    end else if (ext_valid_i) begin
      ext_ready_o <= (cnt_q == wait_i);
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // elak_ext_mem

// ### bench/tb_elak_top.sv
// self-checking bench for the lane aligner
`timescale 1ns/1ps
`include "elak_defs.svh"
module tb_elak_top;
  import elak_pkg::*;
  logic clk_i, resetn_i, endian_select_pin_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic req_valid_i, req_ready_o, rsp_valid_o, ext_valid_o, ext_ready_i;
  logic lane3_write_strobe_n_o, lane2_write_strobe_n_o, lane1_write_strobe_n_o, lane0_write_strobe_n_o;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rsp_rdata_o, ext_rdata_i;
  logic [3:0] s_axi_wstrb_i, wait_q;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  elak_req_type req_i;
  elak_ext_type ext_o;
  elak_ext_type beats[$];
  int err_total, compares;
  elak_top i_elak_top (.clk_i, .resetn_i, .endian_select_pin_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .req_i, .req_valid_i, .req_ready_o, .rsp_rdata_o,
    .rsp_valid_o, .ext_o, .ext_valid_o, .ext_ready_i, .ext_rdata_i, .lane3_write_strobe_n_o,
    .lane2_write_strobe_n_o, .lane1_write_strobe_n_o, .lane0_write_strobe_n_o);
  elak_ext_mem i_elak_ext_mem (.clk_i, .resetn_i, .ext_i(ext_o), .ext_valid_i(ext_valid_o), .wait_i(wait_q),
    .ext_ready_o(ext_ready_i), .ext_rdata_o(ext_rdata_i));
  ////////////////////////////////////////
  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // beats are logged mid-cycle, away from the edge that moves them
  always @(negedge clk_i) if (ext_valid_o && ext_ready_i) beats.push_back(ext_o);
  ////////////////////////////////////////
  task automatic chk(input logic [99:0] g, input logic [99:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rst(input logic pin);
    resetn_i <= 1'b0;
    endian_select_pin_i <= pin;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // write: address and data offered together, response awaited under a bound
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic ta, tw, tb;
    logic [1:0] rs;
    int n;
    n = 0;
    tb = 1'b0;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!tb && n < 50) begin
      @(negedge clk_i);
      ta = s_axi_awvalid_i && s_axi_awready_o;
      tw = s_axi_wvalid_i && s_axi_wready_o;
      tb = s_axi_bvalid_o;
      rs = s_axi_bresp_o;
      @(posedge clk_i);
      if (ta) s_axi_awvalid_i <= 1'b0;
      if (tw) s_axi_wvalid_i <= 1'b0;
      n++;
    end
    s_axi_bready_i <= 1'b0;
    chk({tb, rs}, {1'b1, r});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    logic ta, tr;
    logic [33:0] got;
    int n;
    n = 0;
    tr = 1'b0;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge clk_i);
      ta = s_axi_arvalid_i && s_axi_arready_o;
      tr = s_axi_rvalid_o;
      got = {s_axi_rresp_o, s_axi_rdata_o & m};
      @(posedge clk_i);
      if (ta) s_axi_arvalid_i <= 1'b0;
      n++;
    end
    s_axi_rready_i <= 1'b0;
    chk({tr, got}, {1'b1, r, e});
  endtask
  // one internal access; beats land in the log
  task automatic acc(input elak_size_type z, input logic [31:0] a, input logic [31:0] d, input logic w,
    output logic [31:0] q);
    logic tk, dn;
    int n;
    n = 0;
    dn = 1'b0;
    beats.delete();
    @(posedge clk_i);
    req_i <= '{addr: a, data: d, write: w, size: z};
    req_valid_i <= 1'b1;
    while (!dn && n < 200) begin
      @(negedge clk_i);
      tk = req_valid_i && req_ready_o;
      dn = rsp_valid_o;
      q = rsp_rdata_o;
      @(posedge clk_i);
      if (tk) req_valid_i <= 1'b0;
      n++;
    end
    chk(dn, 1'b1);
  endtask
  ////////////////////////////////////////
  // reset values, unmapped place, keyed writes good and bad
  task automatic t_regs();
    logic [11:0] o;
    for (int i = 0; i < 4; i++) rd(12'(i * 4), 32'h0, 32'hffffffff, `ELAK_RESP_OKAY);
    rd(`ELAK_OFF_XCTL, 32'h2, 32'h3, `ELAK_RESP_OKAY);
    rd(`ELAK_OFF_XSTAT, 32'h2, 32'h3, `ELAK_RESP_OKAY);
    rd(12'h018, 32'h0, 32'hffffffff, `ELAK_RESP_SLVERR);
    wr(12'h018, 32'h0, 4'hf, `ELAK_RESP_SLVERR);
    for (int i = 1; i < 4; i++) begin
      o = 12'(i * 4);
      wr(o, {16'h0, `ELAK_KEY8, 8'h30 + 8'(i)}, 4'h3, `ELAK_RESP_OKAY);
      wr(o, {16'h0, 8'ha4, 8'h5a}, 4'h3, `ELAK_RESP_OKAY);
      wr(o, {16'h0, `ELAK_KEY8, 8'h5a}, 4'h1, `ELAK_RESP_OKAY);
      rd(o, {24'h0, 8'h30 + 8'(i)}, 32'hffffffff, `ELAK_RESP_OKAY);
      wr(o, {`ELAK_KEY8, 8'h70 + 8'(i), 16'h0}, 4'hc, `ELAK_RESP_OKAY);
      rd(o, {24'h0, 8'h70 + 8'(i)}, 32'hffffffff, `ELAK_RESP_OKAY);
    end
    wr(`ELAK_OFF_RFCNT, {16'h0, `ELAK_KEY6, 10'h2ab}, 4'h3, `ELAK_RESP_OKAY);
    wr(`ELAK_OFF_RFCNT, {16'h0, 6'h28, 10'h155}, 4'h3, `ELAK_RESP_OKAY);
    rd(`ELAK_OFF_RFCNT, 32'h2ab, 32'hffffffff, `ELAK_RESP_OKAY);
    $display("register test done");
  endtask
  // every access size at each aligned offset on one device width, writes then reads with wait states
  task automatic t_lanes(input logic [1:0] w);
    int nb, sb, bpb, p, ln, c7;
    logic [31:0] a, d, x, ed, mk, res, q;
    logic [3:0] es;
    elak_size_type z;
    nb = 1 << w;
    wr(`ELAK_OFF_XCTL, {30'h0, w}, 4'hf, `ELAK_RESP_OKAY);
    for (int c = 0; c < 14; c++) begin
      c7 = c % 7;
      z = (c7 < 4) ? ELAK_SZ_BYTE : (c7 < 6) ? ELAK_SZ_WORD : ELAK_SZ_LONG;
      sb = 1 << z;
      a = 32'h100 + ((c7 < 4) ? c7 : (c7 == 5) ? 2 : 0);
      d = 32'hc1d2e3f4 >> (8 * (4 - sb));
      bpb = (sb < nb) ? sb : nb;
      wait_q <= 4'(c % 3);
      acc(z, a, d, c < 7, q);
      chk(beats.size(), sb / bpb);
      res = 32'h0;
      for (int k = 0; k < sb / bpb && k < beats.size(); k++) begin
        ed = 32'h0;
        es = 4'h0;
        for (int j = 0; j < bpb; j++) begin
          p = k * bpb + j;
          x = a + p;
          ln = nb - 1 - x % nb;
          es[ln] = 1'b1;
          ed[8 * ln +: 8] = d[8 * (sb - 1 - p) +: 8];
          res[8 * (sb - 1 - p) +: 8] = {6'(a + k * bpb), 2'(ln)};
        end
        mk = {{8{es[3]}}, {8{es[2]}}, {8{es[1]}}, {8{es[0]}}} & {32{c < 7}};
        chk({beats[k].addr, beats[k].data & mk, beats[k].strobe, beats[k].write},
          {a + k * bpb, ed & mk, es, c < 7});
      end
      if (c >= 7) chk(q, res);
    end
    $display("lane test done for %0d-byte device", nb);
  endtask
  // strap high at a fresh reset selects the mirrored lanes
  task automatic t_little();
    logic [31:0] q;
    rst(1'b1);
    rd(`ELAK_OFF_XSTAT, 32'h3, 32'h3, `ELAK_RESP_OKAY);
    acc(ELAK_SZ_BYTE, 32'h100, 32'h5a, 1'b1, q);
    chk({beats[0].strobe, beats[0].data[7:0]}, {4'h1, 8'h5a});
    acc(ELAK_SZ_WORD, 32'h100, 32'hc1d2, 1'b1, q);
    chk({beats[0].strobe, beats[0].data[15:0]}, {4'h3, 16'hc1d2});
    $display("little-endian test done");
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    err_total = 0;
    compares = 0;
    {resetn_i, endian_select_pin_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
    {s_axi_arvalid_i, s_axi_rready_i, req_valid_i, wait_q, s_axi_wstrb_i} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, req_i} = '0;
    rst(1'b0);
    t_regs();
    for (int w = 0; w < 3; w++) t_lanes(2'(w));
    t_little();
    results();
  end
  // watchdog against a hang
  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule // tb_elak_top
